/* verilog/ready_line_pkg.sv */
// Constants shared by the ready-line serial target port
package ready_line_pkg;

   // ----------------------------------------------------------------
   // Core-side register offsets and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_TIMEOUT = 8'h04;
   localparam logic [7:0] REG_RATE = 8'h08;
   localparam logic [7:0] REG_EVENT = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [1:0] MEM_WINDOW = 2'h1;
   localparam int CTRL_STREAM = 0;
   localparam int CTRL_STOPIGN = 1;
   localparam int CTRL_TUNING = 2;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam logic [7:0] RATE_RESET = 8'h0A;

   // ----------------------------------------------------------------
   // Serial word space and bytes
   // ----------------------------------------------------------------
   localparam logic [7:0] EVENT_ADDR = 8'h10;
   localparam logic [7:0] INVALID_BYTE = 8'hEE;
   localparam logic [7:0] END_CMD = 8'hFF;
   localparam logic [6:0] PRIMARY_ADDR = 7'h2A; // Arbitrary value

   // ----------------------------------------------------------------
   // Timing, in milliseconds unless named otherwise
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES_DOC = MS_NS / CLK_PERIOD_NS;
   localparam logic [7:0] WDOG_MS = 8'hFF;
   localparam logic [7:0] TIMEOUT_RESET_MS = 8'hC8;
   localparam logic [7:0] TIMEOUT_MIN_MS = 8'h02;
   localparam logic [7:0] TIMEOUT_MAX_MS = 8'hE6;
   localparam logic [7:0] FORCE_WAIT_MS = 8'h01;
   localparam logic [3:0] STRETCH_CYCLES = 4'h4;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_ADDR = 3'b001,
      S_ACK = 3'b010,
      S_RXB = 3'b011,
      S_TXB = 3'b100,
      S_TXACK = 3'b101,
      S_TXLD = 3'b110
   } link_state_type;

endpackage

/* verilog/pin_sync3.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync3 #(
   parameter int W = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;

   // A bit only moves once the second and third stages agree
   always_comb
   begin
      lvl_d = lvl_q;
      for (int i = 0; i < W; i++)
      begin
         if (s2_q[i] == s3_q[i])
            lvl_d[i] = s3_q[i];
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_q <= '1;
         s2_q <= '1;
         s3_q <= '1;
         lvl_q <= '1;
      end
      else
      begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
      end
   end

   assign q = lvl_q;
endmodule // pin_sync3

/* verilog/ready_line_i2c_host_port.sv */
// Serial target port with ready line, window timing and watchdog
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/100ps
module ready_line_i2c_host_port
   import ready_line_pkg::*;
#(
   parameter int DEPTH = 16,
   parameter int MS_CYCLES = MS_CYCLES_DOC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sclIn,
   output logic sclOut,
   output logic sclOeN,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOeN,
   output logic rdyOut,
   output logic rdyOeN,
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic we,
   input wire logic re,
   output logic [15:0] rdata,
   output logic swReset
);
   localparam int IW = $clog2(DEPTH);
   localparam int MW = $clog2(MS_CYCLES);

   if (DEPTH < 2 || DEPTH > 16 || MS_CYCLES < 2)
   begin : badParam
      $error("DEPTH must be 2..16 and MS_CYCLES at least 2");
   end

   function automatic logic [7:0] clampMs(input logic [7:0] v);
      if (v < TIMEOUT_MIN_MS)
         return TIMEOUT_MIN_MS;
      if (v > TIMEOUT_MAX_MS)
         return TIMEOUT_MAX_MS;
      return v;
   endfunction

   // ----------------------------------------------------------------
   // Pin sampling
   // ----------------------------------------------------------------
   logic [1:0] pinLvl, pinPrev_q;
   logic sclS, sdaS, sclRise, sclFall, startSeen, stopSeen;

   pin_sync3 #(.W(2)) pinSync (
      .clk(clk),
      .rst_n(rst_n),
      .d({sclIn, sdaIn}),
      .q(pinLvl)
   );

   assign sclS = pinLvl[1];
   assign sdaS = pinLvl[0];
   assign sclRise = sclS & ~pinPrev_q[1];
   assign sclFall = ~sclS & pinPrev_q[1];
   assign startSeen = sclS & pinPrev_q[1] & ~sdaS & pinPrev_q[0];
   assign stopSeen = sclS & pinPrev_q[1] & sdaS & ~pinPrev_q[0];

   // ----------------------------------------------------------------
   // State declarations
   // ----------------------------------------------------------------
   logic [15:0] mem_q [DEPTH];
   logic [2:0] ctrl_q, ctrl_d;
   logic [7:0] timeout_q, timeout_d, rate_q, rate_d, flags_q, flags_d;
   logic resetEvent_q, resetEvent_d, pinLow_q;
   logic [15:0] rdata_q, rdata_d;
   logic [MW-1:0] msCnt_q, msCnt_d;
   logic tick, rdyOeN_q, rdyOeN_d, started_q, started_d, forceReq_q, forceReq_d;
   logic swReset_q, swReset_d;
   logic [7:0] winTimer_q, winTimer_d, rateCnt_q, rateCnt_d;
   logic [7:0] forceCnt_q, forceCnt_d, wdog_q, wdog_d;
   link_state_type state_q, state_d;
   logic [2:0] bitCnt_q, bitCnt_d;
   logic [7:0] shift_q, shift_d, ptr_q, ptr_d, loByte_q, loByte_d, rxByte, txByte;
   logic rw_q, rw_d, byteSel_q, byteSel_d, first_q, first_d, ackOn_q, ackOn_d;
   logic sdaOeN_q, sdaOeN_d, sclOeN_q, sclOeN_d;
   logic [3:0] stretch_q, stretch_d;
   logic byteDone, endCmd, flagClr, memWe, addrOk, holdOff;
   logic [3:0] coreIdx;
   logic coreMem;

   assign tick = (msCnt_q == MW'(MS_CYCLES - 1));
   assign rxByte = {shift_q[6:0], sdaS};
   assign holdOff = ctrl_q[CTRL_TUNING] & ~resetEvent_q;
   assign addrOk = (rxByte[7:1] == PRIMARY_ADDR) ||
      (rxByte[7:1] == {PRIMARY_ADDR[6:1], ~PRIMARY_ADDR[0]});
   assign coreIdx = addr[5:2];
   assign coreMem = (addr[7:6] == MEM_WINDOW) && (addr[1:0] == 2'h0) &&
      ({4'h0, coreIdx} < 8'(DEPTH));

   // Read byte selection: low byte first, 0xEE for holes or closed window
   always_comb
   begin
      if (rdyOeN_q)
         txByte = INVALID_BYTE;
      else if (ptr_q < 8'(DEPTH))
         txByte = byteSel_q ? mem_q[ptr_q[IW-1:0]][15:8] : mem_q[ptr_q[IW-1:0]][7:0];
      else if (ptr_q == EVENT_ADDR)
         txByte = byteSel_q ? {resetEvent_q, 7'h00} : flags_q;
      else
         txByte = INVALID_BYTE;
   end

   // ----------------------------------------------------------------
   // Serial link engine
   // ----------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      bitCnt_d = bitCnt_q;
      shift_d = shift_q;
      ptr_d = ptr_q;
      rw_d = rw_q;
      loByte_d = loByte_q;
      byteSel_d = byteSel_q;
      first_d = first_q;
      ackOn_d = ackOn_q;
      sdaOeN_d = sdaOeN_q;
      stretch_d = (stretch_q != 4'h0) ? stretch_q - 4'h1 : 4'h0;
      sclOeN_d = (stretch_q == 4'h0);
      byteDone = 1'b0;
      endCmd = 1'b0;
      flagClr = 1'b0;
      memWe = 1'b0;
      case (state_q)
         S_ADDR:
            if (sclRise)
            begin
               shift_d = rxByte;
               bitCnt_d = bitCnt_q + 3'h1;
               if (bitCnt_q == 3'h7)
               begin
                  rw_d = rxByte[0];
                  byteDone = 1'b1;
                  state_d = (addrOk && !holdOff) ? S_ACK : S_IDLE;
               end
            end
         S_ACK:
            if (sclFall)
            begin
               ackOn_d = ~ackOn_q;
               sdaOeN_d = ackOn_q;
               if (ackOn_q && rw_q)
               begin
                  state_d = S_TXLD;
                  sclOeN_d = 1'b0;
               end
               else if (ackOn_q)
                  state_d = S_RXB;
            end
         S_RXB:
            if (sclRise)
            begin
               shift_d = rxByte;
               bitCnt_d = bitCnt_q + 3'h1;
               if (bitCnt_q == 3'h7)
               begin
                  byteDone = 1'b1;
                  first_d = 1'b0;
                  state_d = S_ACK;
                  if (first_q && rxByte == END_CMD && ctrl_q[CTRL_STOPIGN])
                     endCmd = 1'b1;
                  else if (first_q)
                  begin
                     ptr_d = rxByte;
                     byteSel_d = 1'b0;
                  end
                  else if (!byteSel_q)
                  begin
                     loByte_d = rxByte;
                     byteSel_d = 1'b1;
                  end
                  else
                  begin
                     memWe = !rdyOeN_q && (ptr_q < 8'(DEPTH));
                     ptr_d = ptr_q + 8'h01;
                     byteSel_d = 1'b0;
                  end
               end
            end
         S_TXLD:
            begin
               // Hold the clock low while the byte is fetched
               shift_d = {txByte[6:0], 1'b0};
               sdaOeN_d = txByte[7];
               bitCnt_d = 3'h0;
               stretch_d = STRETCH_CYCLES;
               sclOeN_d = 1'b0;
               flagClr = byteSel_q && ptr_q == EVENT_ADDR && !rdyOeN_q;
               state_d = S_TXB;
            end
         S_TXB:
            if (sclFall)
            begin
               bitCnt_d = bitCnt_q + 3'h1;
               if (bitCnt_q == 3'h7)
               begin
                  sdaOeN_d = 1'b1;
                  state_d = S_TXACK;
               end
               else
               begin
                  sdaOeN_d = shift_q[7];
                  shift_d = {shift_q[6:0], 1'b0};
               end
            end
         S_TXACK:
            if (sclRise)
            begin
               byteDone = 1'b1;
               byteSel_d = ~byteSel_q;
               if (byteSel_q)
                  ptr_d = ptr_q + 8'h01;
               state_d = sdaS ? S_IDLE : S_ACK;
               ackOn_d = 1'b1;
               rw_d = 1'b1;
            end
         S_IDLE: ;
         default: state_d = S_IDLE;
      endcase
      // A host acknowledge leaves the data line to the host
      if (state_q == S_TXACK && sclRise && !sdaS)
         ackOn_d = 1'b1;
      if (startSeen)
      begin
         state_d = S_ADDR;
         bitCnt_d = 3'h0;
         first_d = 1'b1;
         ackOn_d = 1'b0;
         sdaOeN_d = 1'b1;
      end
      if (stopSeen || swReset_q)
      begin
         state_d = S_IDLE;
         sdaOeN_d = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pinPrev_q <= 2'h3;
         state_q <= S_IDLE;
         bitCnt_q <= 3'h0;
         shift_q <= 8'h00;
         ptr_q <= 8'h00;
         rw_q <= 1'b0;
         loByte_q <= 8'h00;
         byteSel_q <= 1'b0;
         first_q <= 1'b0;
         ackOn_q <= 1'b0;
         sdaOeN_q <= 1'b1;
         sclOeN_q <= 1'b1;
         stretch_q <= 4'h0;
      end
      else
      begin
         pinPrev_q <= pinLvl;
         state_q <= state_d;
         bitCnt_q <= bitCnt_d;
         shift_q <= shift_d;
         ptr_q <= ptr_d;
         rw_q <= rw_d;
         loByte_q <= loByte_d;
         byteSel_q <= byteSel_d;
         first_q <= first_d;
         ackOn_q <= ackOn_d;
         sdaOeN_q <= sdaOeN_d;
         sclOeN_q <= sclOeN_d;
         stretch_q <= stretch_d;
      end
   end

   // ----------------------------------------------------------------
   // Window, timeouts and watchdog
   // ----------------------------------------------------------------
   always_comb
   begin
      msCnt_d = tick ? '0 : msCnt_q + 1'b1;
      rdyOeN_d = rdyOeN_q;
      winTimer_d = winTimer_q;
      started_d = started_q;
      rateCnt_d = (tick && rateCnt_q != 8'hFF) ? rateCnt_q + 8'h01 : rateCnt_q;
      forceReq_d = forceReq_q;
      forceCnt_d = forceCnt_q;
      swReset_d = 1'b0;
      if (rdyOeN_q)
      begin
         winTimer_d = 8'h00;
         started_d = 1'b0;
         if (startSeen)
            forceReq_d = 1'b1;
         if (forceReq_q && tick)
            forceCnt_d = forceCnt_q + 8'h01;
         if ((ctrl_q[CTRL_STREAM] && rateCnt_q >= rate_q) ||
            (!ctrl_q[CTRL_STREAM] && (flags_q != 8'h00 || resetEvent_q)) ||
            (forceReq_q && forceCnt_q >= FORCE_WAIT_MS))
         begin
            rdyOeN_d = 1'b0;
            rateCnt_d = 8'h00;
            forceReq_d = 1'b0;
            forceCnt_d = 8'h00;
         end
      end
      else
      begin
         if (startSeen)
            started_d = 1'b1;
         if (!started_q && tick)
            winTimer_d = winTimer_q + 8'h01;
         if ((stopSeen && !ctrl_q[CTRL_STOPIGN]) || endCmd ||
            (!started_q && winTimer_q >= timeout_q))
            rdyOeN_d = 1'b1;
      end
      // Restart the prescaler so window and watchdog spans run whole milliseconds
      if ((rdyOeN_q && !rdyOeN_d) || (byteDone && !rdyOeN_q))
         msCnt_d = '0;
      if (rdyOeN_q || byteDone)
         wdog_d = 8'h00;
      else
         wdog_d = tick ? wdog_q + 8'h01 : wdog_q;
      if (wdog_q == WDOG_MS)
      begin
         swReset_d = 1'b1;
         rdyOeN_d = 1'b1;
         wdog_d = 8'h00;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         msCnt_q <= '0;
         rdyOeN_q <= 1'b1;
         winTimer_q <= 8'h00;
         started_q <= 1'b0;
         rateCnt_q <= 8'h00;
         forceReq_q <= 1'b0;
         forceCnt_q <= 8'h00;
         wdog_q <= 8'h00;
         swReset_q <= 1'b0;
      end
      else
      begin
         msCnt_q <= msCnt_d;
         rdyOeN_q <= rdyOeN_d;
         winTimer_q <= winTimer_d;
         started_q <= started_d;
         rateCnt_q <= rateCnt_d;
         forceReq_q <= forceReq_d;
         forceCnt_q <= forceCnt_d;
         wdog_q <= wdog_d;
         swReset_q <= swReset_d;
      end
   end

   // ----------------------------------------------------------------
   // Core register port and word store
   // ----------------------------------------------------------------
   always_comb
   begin
      ctrl_d = ctrl_q;
      timeout_d = timeout_q;
      rate_d = rate_q;
      flags_d = flags_q & ~{8{flagClr}};
      rdata_d = 16'h0000;
      if (we)
      begin
         case (addr)
            REG_CTRL: ctrl_d = wdata[2:0];
            REG_TIMEOUT: timeout_d = clampMs(wdata[7:0]);
            REG_RATE: rate_d = wdata[7:0];
            REG_EVENT: flags_d = flags_d | wdata[7:0];
            default: ;
         endcase
      end
      resetEvent_d = swReset_q | (resetEvent_q & ~flagClr);
      if (re)
      begin
         case (addr)
            REG_CTRL: rdata_d = {13'h0000, ctrl_q};
            REG_TIMEOUT: rdata_d = {8'h00, timeout_q};
            REG_RATE: rdata_d = {8'h00, rate_q};
            REG_EVENT: rdata_d = {8'h00, flags_q};
            REG_STATUS: rdata_d = {12'h000, holdOff, started_q, ~rdyOeN_q, resetEvent_q};
            default: rdata_d = coreMem ? mem_q[coreIdx[IW-1:0]] : 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_q <= CTRL_RESET;
         timeout_q <= TIMEOUT_RESET_MS;
         rate_q <= RATE_RESET;
         flags_q <= 8'h00;
         resetEvent_q <= 1'b1;
         rdata_q <= 16'h0000;
         pinLow_q <= 1'b0;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         timeout_q <= timeout_d;
         rate_q <= rate_d;
         flags_q <= flags_d;
         resetEvent_q <= resetEvent_d;
         rdata_q <= rdata_d;
         pinLow_q <= 1'b0;
      end
   end

   // Serial writes win over a core write to the same cycle
   always_ff @(posedge clk)
   begin
      if (memWe)
         mem_q[ptr_q[IW-1:0]] <= {rxByte, loByte_q};
      else if (we && coreMem)
         mem_q[coreIdx[IW-1:0]] <= wdata;
   end

   assign sclOut = pinLow_q;
   assign sclOeN = sclOeN_q;
   assign sdaOut = pinLow_q;
   assign sdaOeN = sdaOeN_q;
   assign rdyOut = pinLow_q;
   assign rdyOeN = rdyOeN_q;
   assign rdata = rdata_q;
   assign swReset = swReset_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   wdog_expire_a: assert property (wdog_q == WDOG_MS |=> swReset_q && rdyOeN_q)
      else $error("watchdog expiry did not reset");
   wdog_kick_a: assert property (byteDone |=> wdog_q == 8'h00)
      else $error("byte did not kick watchdog");
   wdog_idle_a: assert property (rdyOeN_q |=> wdog_q == 8'h00)
      else $error("watchdog ran outside window");
   clock_stretch_a: assert property (state_q == S_TXLD |=> !sclOeN_q [*4])
      else $error("clock not stretched on byte load");
   read_advance_a: assert property (state_q == S_TXACK && sclRise && byteSel_q
      |=> ptr_q == $past(ptr_q) + 8'h01)
      else $error("pointer did not advance after high byte");
   tuning_hold_a: assert property (state_q == S_ADDR && sclRise && bitCnt_q == 3'h7
      && holdOff |=> state_q == S_IDLE)
      else $error("answered during tuning");
   window_timeout_a: assert property (!rdyOeN_q && !started_q && winTimer_q >= timeout_q
      |=> rdyOeN_q)
      else $error("window outlived its timeout");
   timeout_off_a: assert property (!rdyOeN_q && started_q |=> $stable(winTimer_q))
      else $error("timeout ran after start");
   stop_close_a: assert property (!rdyOeN_q && stopSeen && !ctrl_q[CTRL_STOPIGN]
      |=> rdyOeN_q)
      else $error("stop did not close window");

   window_open_c: cover property (rdyOeN_q ##1 !rdyOeN_q);
   read_word_c: cover property (state_q == S_TXACK && sclRise && byteSel_q && !sdaS);
   end_cmd_c: cover property (endCmd);
   wdog_fire_c: cover property (swReset_q);
endmodule // ready_line_i2c_host_port

/* sim/host_bus_model.sv */
// Behavioural serial bus controller on open-drain lines
`timescale 1ns/100ps
module host_bus_model (
   input wire logic clk,
   input wire logic sclOeN,
   input wire logic sdaOeN,
   output logic sclLine,
   output logic sdaLine
);
   // ------------------------------------------------------------
   // Lines with pull-ups: low while either party pulls them
   // ------------------------------------------------------------
   logic sclDrv = 1'b1;
   logic sdaDrv = 1'b1;
   assign sclLine = sclDrv & sclOeN;
   assign sdaLine = sdaDrv & sdaOeN;

   task automatic q();
      repeat (4) @(posedge clk);
   endtask

   // Release the clock, then wait while the target stretches it
   task automatic hi();
      sclDrv <= 1'b1;
      @(posedge clk);
      for (int k = 0; k < 100 && !sclLine; k++)
         @(posedge clk);
   endtask

   task automatic bitx(input logic b, output logic s);
      sdaDrv <= b;
      q();
      hi();
      repeat (3) @(posedge clk);
      s = sdaLine;
      q();
      sclDrv <= 1'b0;
      q();
   endtask

   task automatic start();
      sdaDrv <= 1'b1;
      q();
      hi();
      q();
      sdaDrv <= 1'b0;
      q();
      sclDrv <= 1'b0;
      q();
   endtask

   task automatic stop();
      sdaDrv <= 1'b0;
      q();
      hi();
      q();
      sdaDrv <= 1'b1;
      q();
   endtask

   task automatic wr(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bitx(b[i], s);
      bitx(1'b1, s);
      ack = !s;
   endtask

   task automatic rd(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--)
         bitx(1'b1, b[i]);
      bitx(last, s);
   endtask
endmodule // host_bus_model

/* sim/ready_line_i2c_host_port_test.sv */
// Self-checking bench for the ready-line serial target port
`timescale 1ns/100ps
module ready_line_i2c_host_port_test
   import ready_line_pkg::*;
;
   // Shortened millisecond keeps the watchdog span inside the run
   localparam int MS = 200;
   localparam logic [7:0] WR_A = {PRIMARY_ADDR, 1'b0};
   localparam logic [7:0] RD_A = {PRIMARY_ADDR, 1'b1};
   localparam logic [7:0] DBG_R = {PRIMARY_ADDR ^ 7'h01, 1'b1};
   logic clk = 1'b0;
   logic rst_n, sclLine, sdaLine, sclOeN, sdaOeN, rdyOut, rdyOeN, swReset, we, re, held;
   logic [7:0] addr;
   logic [15:0] wdata, rdata, n;
   int failures = 0;
   int compares = 0;

   ready_line_i2c_host_port #(.MS_CYCLES(MS)) uut (
      .clk(clk), .rst_n(rst_n), .sclIn(sclLine), .sclOut(), .sclOeN(sclOeN),
      .sdaIn(sdaLine), .sdaOut(), .sdaOeN(sdaOeN), .rdyOut(rdyOut), .rdyOeN(rdyOeN),
      .addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata), .swReset(swReset)
   );
   host_bus_model host (
      .clk(clk), .sclOeN(sclOeN), .sdaOeN(sdaOeN), .sclLine(sclLine), .sdaLine(sdaLine)
   );

   always #5 clk = ~clk;

   // ------------------------------------------------------------
   // Access and compare tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      compares++;
      if (g !== e)
      begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic cw(input logic [7:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
      @(posedge clk);
   endtask

   task automatic cr(input logic [7:0] a, input logic [15:0] e);
      addr <= a;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      #1 chk(rdata, e);
      @(posedge clk);
   endtask

   task automatic sw(input logic [7:0] b, input logic e);
      logic a;
      host.wr(b, a);
      chk(16'(a), 16'(e));
   endtask

   task automatic sr(input logic last, input logic [7:0] e);
      logic [7:0] b;
      host.rd(last, b);
      chk({8'h00, b}, {8'h00, e});
   endtask

   task automatic setPtr(input logic [7:0] p);
      host.start();
      sw(WR_A, 1'b1);
      sw(p, 1'b1);
   endtask

   task automatic waitRdy(input logic v);
      for (int k = 0; k < 400 && rdyOeN !== v; k++)
         @(posedge clk);
      chk(16'(rdyOeN), 16'(v));
   endtask

   task automatic close_out();
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial
   begin
      {we, re, addr, wdata} = '0;
      rst_n = 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      cr(REG_CTRL, 16'h0000);
      cr(REG_TIMEOUT, 16'h00C8);
      cr(REG_RATE, 16'h000A);
      waitRdy(1'b0);
      cr(REG_STATUS, 16'h0003);
      chk(16'(rdyOeN | rdyOut), 16'h0000);
      setPtr(EVENT_ADDR);
      host.start();
      sw(RD_A, 1'b1);
      sr(1'b0, 8'h00);
      sr(1'b1, 8'h80);
      host.stop();
      waitRdy(1'b1);
      cr(REG_STATUS, 16'h0000);
      $display("test reset done");
      // Read while closed; the same start also forces a window
      host.start();
      sw(DBG_R, 1'b1);
      sr(1'b1, INVALID_BYTE);
      waitRdy(1'b0);
      host.start();
      sw(8'h58, 1'b0);
      setPtr(8'h01);
      sw(8'h34, 1'b1);
      sw(8'h12, 1'b1);
      sw(8'h78, 1'b1);
      sw(8'h56, 1'b1);
      setPtr(8'h01);
      host.start();
      sw(RD_A, 1'b1);
      sr(1'b0, 8'h34);
      sr(1'b0, 8'h12);
      sr(1'b0, 8'h78);
      sr(1'b1, 8'h56);
      setPtr(8'h20);
      host.start();
      sw(RD_A, 1'b1);
      sr(1'b1, INVALID_BYTE);
      host.stop();
      waitRdy(1'b1);
      cr(8'h44, 16'h1234);
      cr(8'h48, 16'h5678);
      $display("test words done");
      cw(REG_CTRL, 16'h0002);
      host.start();
      sw(WR_A, 1'b1);
      waitRdy(1'b0);
      setPtr(8'h03);
      host.stop();
      repeat (20) @(posedge clk);
      chk(16'(rdyOeN), 16'h0000);
      setPtr(END_CMD);
      waitRdy(1'b1);
      host.stop();
      cw(REG_CTRL, 16'h0000);
      $display("test stop ignore done");
      cw(REG_TIMEOUT, 16'h00FF);
      cr(REG_TIMEOUT, {8'h00, TIMEOUT_MAX_MS});
      cw(REG_TIMEOUT, 16'h0001);
      cr(REG_TIMEOUT, {8'h00, TIMEOUT_MIN_MS});
      cw(REG_EVENT, 16'h0001);
      waitRdy(1'b0);
      n = '0;
      while (rdyOeN === 1'b0 && n < 16'd2000)
      begin
         @(posedge clk);
         n++;
      end
      chk(16'(n >= 2 * MS - 3 && n <= 2 * MS + 3), 16'h0001);
      waitRdy(1'b0);
      setPtr(EVENT_ADDR);
      host.start();
      sw(RD_A, 1'b1);
      sr(1'b0, 8'h01);
      sr(1'b1, 8'h00);
      host.stop();
      waitRdy(1'b1);
      cr(REG_STATUS, 16'h0000);
      $display("test timeout done");
      cw(REG_RATE, 16'h0004);
      repeat (4 * MS) @(posedge clk);
      cw(REG_CTRL, 16'h0001);
      waitRdy(1'b0);
      n = '0;
      while (rdyOeN === 1'b0 && n < 16'd2000)
      begin
         @(posedge clk);
         n++;
      end
      while (rdyOeN === 1'b1 && n < 16'd2000)
      begin
         @(posedge clk);
         n++;
      end
      chk(16'(n >= 4 * MS - 3 && n <= 4 * MS + 3), 16'h0001);
      cw(REG_CTRL, 16'h0000);
      $display("test stream done");
      cw(REG_CTRL, 16'h0004);
      host.start();
      sw(WR_A, 1'b0);
      host.stop();
      cw(REG_CTRL, 16'h0000);
      host.start();
      sw(WR_A, 1'b1);
      waitRdy(1'b0);
      host.start();
      sw(WR_A, 1'b1);
      n = '0;
      held = 1'b1;
      while (swReset !== 1'b1 && n < 16'd60000)
      begin
         held &= (rdyOeN === 1'b0);
         @(posedge clk);
         n++;
      end
      chk(16'(held), 16'h0001);
      chk(16'(n > 255 * MS - 40 && n < 255 * MS + 10), 16'h0001);
      waitRdy(1'b0);
      cr(REG_STATUS, 16'h0003);
      $display("test watchdog done");
      close_out();
   end

   initial
   begin
      repeat (80000) @(posedge clk);
      failures++;
      close_out();
   end
endmodule // ready_line_i2c_host_port_test
